// ---- verilog/cprl_pkg.sv ----
// Constants for the counter parameter record loader
package cprl_pkg;

  // ==========================================================
  // Record identity and header
  localparam logic [7:0]  REC_INDEX      = 8'h80;
  localparam logic [7:0]  HDR_VERSION    = 8'h01;
  localparam logic [7:0]  HDR_CH_LEN     = 8'h30;
  localparam logic [7:0]  HDR_SPARE      = 8'h00;
  localparam logic [7:0]  REC_MIN_LEN    = 8'h07;
  localparam logic [7:0]  REC_MAX_CNT    = 8'hFF;

  // ==========================================================
  // Byte offsets in the record
  localparam logic [7:0]  OFS_VERSION    = 8'h00;
  localparam logic [7:0]  OFS_CH_LEN     = 8'h01;
  localparam logic [7:0]  OFS_SPARE_A    = 8'h02;
  localparam logic [7:0]  OFS_SPARE_B    = 8'h03;
  localparam logic [7:0]  OFS_FUNC       = 8'h04;
  localparam logic [7:0]  OFS_BASIC      = 8'h05;
  localparam logic [7:0]  OFS_ENC        = 8'h06;

  // ==========================================================
  // Field positions and reserved masks
  localparam int          BAS_IFACE_BIT  = 7;
  localparam int          BAS_DIAG_BIT   = 2;
  localparam logic [7:0]  FUNC_RSV_MASK  = 8'hF0;
  localparam logic [7:0]  BAS_RSV_MASK   = 8'h78;
  localparam logic [7:0]  ENC_RSV_MASK   = 8'hC0;
  localparam int          ENC_EVAL_LSB   = 4;

  // ==========================================================
  // Field encodings
  localparam logic [3:0]  MODE_COUNT     = 4'h1;
  localparam logic [3:0]  MODE_MEASURE   = 4'h2;
  localparam logic [1:0]  STOP_SUBST     = 2'h0;
  localparam logic [1:0]  STOP_HOLD      = 2'h1;
  localparam logic [1:0]  STOP_CONTINUE  = 2'h2;
  localparam logic [1:0]  STOP_RSV       = 2'h3;
  localparam logic [1:0]  EVAL_SINGLE    = 2'h0;
  localparam logic [1:0]  EVAL_DOUBLE    = 2'h1;
  localparam logic [1:0]  EVAL_QUAD      = 2'h2;
  localparam logic [1:0]  EVAL_RSV       = 2'h3;
  localparam logic [3:0]  SIG_PULSE      = 4'h0;
  localparam logic [3:0]  SIG_CNT_DIR    = 4'h1;
  localparam logic [3:0]  SIG_CNT_UPDN   = 4'h2;
  localparam logic [3:0]  SIG_INCR_AB    = 4'h3;
  localparam logic [3:0]  SIG_INCR_ABN   = 4'h4;

  // ==========================================================
  // Completion error codes (values arbitrary)
  localparam logic [15:0] ERR_NONE       = 16'h0000;
  localparam logic [15:0] ERR_INDEX      = 16'h80B0;
  localparam logic [15:0] ERR_LENGTH     = 16'h80B1;
  localparam logic [15:0] ERR_HEADER     = 16'h80E0;
  localparam logic [15:0] ERR_RESERVED   = 16'h80E1;
  localparam logic [15:0] ERR_MODE_RUN   = 16'h80E2;

  // ==========================================================
  // Reset configuration
  localparam logic [3:0]  RST_MODE       = 4'h0;
  localparam logic [7:0]  RST_BASIC      = 8'h00;
  localparam logic [7:0]  RST_ENC        = 8'h00;

  typedef enum logic [0:0] {
    CPRL_ST_IDLE = 1'b0,
    CPRL_ST_RECV = 1'b1
  } cprl_state_t;

endpackage

// ---- verilog/cprl_byte_check.sv ----
// Per-byte validation of an incoming parameter record
`timescale 1ns/10ps
module cprl_byte_check (
  // Byte under test
  input  wire logic [7:0]  i_offset,
  input  wire logic [7:0]  i_data,
  // Context
  input  wire logic        i_full,
  input  wire logic        i_cfg_valid,
  input  wire logic [3:0]  i_active_mode,
  // Verdict
  output logic             o_ok,
  output logic [15:0]      o_code
);

  // ==========================================================
  // Field decoders
  function automatic logic mode_legal(input logic [3:0] m);
    return (m == cprl_pkg::MODE_COUNT) || (m == cprl_pkg::MODE_MEASURE);
  endfunction

  function automatic logic sig_legal(input logic [3:0] s);
    return (s == cprl_pkg::SIG_PULSE) || (s == cprl_pkg::SIG_CNT_DIR) ||
           (s == cprl_pkg::SIG_CNT_UPDN) || (s == cprl_pkg::SIG_INCR_AB) ||
           (s == cprl_pkg::SIG_INCR_ABN);
  endfunction

  // ==========================================================
  // Verdict per offset
  always_comb begin
    o_code = cprl_pkg::ERR_NONE;
    case (i_offset)
      cprl_pkg::OFS_VERSION: begin
        if (i_data != cprl_pkg::HDR_VERSION) o_code = cprl_pkg::ERR_HEADER; // [R5] [R14]
      end
      cprl_pkg::OFS_CH_LEN: begin
        if (i_data != cprl_pkg::HDR_CH_LEN) o_code = cprl_pkg::ERR_HEADER; // [R5] [R14]
      end
      cprl_pkg::OFS_SPARE_A, cprl_pkg::OFS_SPARE_B: begin
        if (i_data != cprl_pkg::HDR_SPARE) o_code = cprl_pkg::ERR_HEADER; // [R5]
      end
      cprl_pkg::OFS_FUNC: begin
        if ((i_data & cprl_pkg::FUNC_RSV_MASK) != 8'h00 ||
            !mode_legal(i_data[3:0])) begin
          o_code = cprl_pkg::ERR_RESERVED; // [R7] [R14]
        end else if (!i_full && i_cfg_valid &&
                     i_data[3:0] != i_active_mode) begin
          o_code = cprl_pkg::ERR_MODE_RUN; // [R6]
        end
      end
      cprl_pkg::OFS_BASIC: begin
        if ((i_data & cprl_pkg::BAS_RSV_MASK) != 8'h00 ||
            i_data[1:0] == cprl_pkg::STOP_RSV) begin
          o_code = cprl_pkg::ERR_RESERVED; // [R9] [R14]
        end
      end
      cprl_pkg::OFS_ENC: begin
        if ((i_data & cprl_pkg::ENC_RSV_MASK) != 8'h00 ||
            i_data[5:4] == cprl_pkg::EVAL_RSV ||
            !sig_legal(i_data[3:0])) begin
          o_code = cprl_pkg::ERR_RESERVED; // [R11] [R13] [R14]
        end
      end
      default: o_code = cprl_pkg::ERR_NONE;
    endcase
    o_ok = (o_code == cprl_pkg::ERR_NONE);
  end

endmodule

// ---- verilog/cprl_loader.sv ----
// Parameter record loader for the position/counter input channel
//
// Operation
// [R1] Full parameter set arrives only as record 128, also while running.
// [R2] An erroneous record is dropped whole; previous configuration stays.
// [R3] A rejected write completes with an error code as status.
// [R4] A good write completes with the count of accepted bytes.
// [R5] Header bytes are fixed: version 0.1, length 48, two zero bytes.
// [R6] Function byte may change only in a full assignment, not at run; a run-time write still sets it while o_cfg_valid is low.
// [R7] Function low nibble: 0001 counting, 0010 measuring; rest reserved.
// [R8] Basic byte bit 7: 0 differential RS422, 1 single-ended 5 V TTL.
// [R9] Stop reaction: 00 substitute, 01 hold, 10 continue, 11 reserved.
// [R10] Evaluation field bits 5:4, value 00 is single evaluation.
// [R11] Evaluation 01 double, 10 quadruple, 11 reserved.
// [R12] Signal type bits 3:0, value 0000 is plain pulse input.
// [R13] Signal type 0011 two-track encoder, 0100 tracks plus zero mark.
// [R14] Header mismatch or reserved encoding makes the record erroneous.
// [R15] Controller writes zero into all reserved bits and bytes.
`timescale 1ns/10ps
module cprl_loader (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Record write service, request side
  input  wire logic        i_rec_start,
  input  wire logic [7:0]  i_rec_index,
  input  wire logic        i_rec_full,
  input  wire logic        i_rec_valid,
  input  wire logic [7:0]  i_rec_data,
  input  wire logic        i_rec_last,
  // Record write service, completion side
  output logic             o_rec_busy,
  output logic             o_rec_done,
  output logic             o_rec_error,
  output logic [15:0]      o_rec_status,
  // Applied configuration
  output logic             o_cfg_valid,
  output logic [3:0]       o_mode,
  output logic             o_iface_ttl,
  output logic             o_diag_en,
  output logic [1:0]       o_stop_react,
  output logic [1:0]       o_eval,
  output logic [3:0]       o_sig_type
);

  // ==========================================================
  // State
  typedef struct packed {
    cprl_pkg::cprl_state_t st;
    logic                  full;
    logic [7:0]            cnt;
    logic [15:0]           code;
    logic [3:0]            stg_mode;
    logic [7:0]            stg_basic;
    logic [7:0]            stg_enc;
    logic                  busy;
    logic                  done;
    logic                  error;
    logic [15:0]           status;
    logic                  cfg_valid;
    logic [3:0]            mode;
    logic [7:0]            basic;
    logic [7:0]            enc;
  } cprl_regs_t;

  localparam cprl_regs_t RST_REGS = '{
    st:        cprl_pkg::CPRL_ST_IDLE,
    full:      1'b0,
    cnt:       8'h00,
    code:      cprl_pkg::ERR_NONE,
    stg_mode:  cprl_pkg::RST_MODE,
    stg_basic: cprl_pkg::RST_BASIC,
    stg_enc:   cprl_pkg::RST_ENC,
    busy:      1'b0,
    done:      1'b0,
    error:     1'b0,
    status:    16'h0000,
    cfg_valid: 1'b0,
    mode:      cprl_pkg::RST_MODE,
    basic:     cprl_pkg::RST_BASIC,
    enc:       cprl_pkg::RST_ENC
  };

  cprl_regs_t  regs_ff;
  cprl_regs_t  nxt_regs;
  logic        chk_ok;
  logic [15:0] chk_code;

  // ==========================================================
  // Byte checker
  cprl_byte_check u_check (
    .i_offset      (regs_ff.cnt),
    .i_data        (i_rec_data),
    .i_full        (regs_ff.full),
    .i_cfg_valid   (regs_ff.cfg_valid),
    .i_active_mode (regs_ff.mode),
    .o_ok          (chk_ok),
    .o_code        (chk_code)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0]  new_cnt;
    logic [15:0] err;
    new_cnt  = regs_ff.cnt;
    err      = regs_ff.code;
    nxt_regs = regs_ff;
    nxt_regs.done = 1'b0;
    case (regs_ff.st)
      cprl_pkg::CPRL_ST_IDLE: begin
        if (i_rec_start) begin
          nxt_regs.st   = cprl_pkg::CPRL_ST_RECV;
          nxt_regs.full = i_rec_full;
          nxt_regs.cnt  = 8'h00;
          nxt_regs.code = cprl_pkg::ERR_NONE;
          if (i_rec_index != cprl_pkg::REC_INDEX) begin
            nxt_regs.code = cprl_pkg::ERR_INDEX; // [R1]
          end
        end
      end
      cprl_pkg::CPRL_ST_RECV: begin
        if (i_rec_valid) begin
          if (regs_ff.cnt == cprl_pkg::REC_MAX_CNT) begin
            if (err == cprl_pkg::ERR_NONE) err = cprl_pkg::ERR_LENGTH;
          end else begin
            new_cnt = 8'(regs_ff.cnt + 8'h01);
          end
          if (err == cprl_pkg::ERR_NONE && !chk_ok) begin
            err = chk_code; // [R14]
          end
          case (regs_ff.cnt)
            cprl_pkg::OFS_FUNC:  nxt_regs.stg_mode  = i_rec_data[3:0];
            cprl_pkg::OFS_BASIC: nxt_regs.stg_basic = i_rec_data;
            cprl_pkg::OFS_ENC:   nxt_regs.stg_enc   = i_rec_data;
            default:             nxt_regs.stg_enc   = regs_ff.stg_enc;
          endcase
          if (i_rec_last) begin
            if (err == cprl_pkg::ERR_NONE &&
                new_cnt < cprl_pkg::REC_MIN_LEN) begin
              err = cprl_pkg::ERR_LENGTH;
            end
            nxt_regs.st   = cprl_pkg::CPRL_ST_IDLE;
            nxt_regs.done = 1'b1;
            if (err != cprl_pkg::ERR_NONE) begin
              nxt_regs.error  = 1'b1;
              nxt_regs.status = err; // [R3] [R2]
            end else begin
              nxt_regs.error     = 1'b0;
              nxt_regs.status    = {8'h00, new_cnt}; // [R4]
              nxt_regs.cfg_valid = 1'b1;
              nxt_regs.mode      = nxt_regs.stg_mode; // [R6] [R7]
              nxt_regs.basic     = nxt_regs.stg_basic; // [R8] [R9]
              nxt_regs.enc       = nxt_regs.stg_enc; // [R10] [R12]
            end
          end
          nxt_regs.cnt  = new_cnt;
          nxt_regs.code = err;
        end
      end
      default: nxt_regs.st = cprl_pkg::CPRL_ST_IDLE;
    endcase
    nxt_regs.busy = (nxt_regs.st == cprl_pkg::CPRL_ST_RECV);
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      regs_ff <= RST_REGS;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rec_busy   = regs_ff.busy;
  assign o_rec_done   = regs_ff.done;
  assign o_rec_error  = regs_ff.error;
  assign o_rec_status = regs_ff.status;
  assign o_cfg_valid  = regs_ff.cfg_valid;
  assign o_mode       = regs_ff.mode;
  assign o_iface_ttl  = regs_ff.basic[cprl_pkg::BAS_IFACE_BIT];
  assign o_diag_en    = regs_ff.basic[cprl_pkg::BAS_DIAG_BIT];
  assign o_stop_react = regs_ff.basic[1:0];
  assign o_eval       = regs_ff.enc[cprl_pkg::ENC_EVAL_LSB +: 2];
  assign o_sig_type   = regs_ff.enc[3:0];

  // ==========================================================
  // Checks
  property p_answer_next;
    @(posedge i_ref_clk) disable iff (i_rst)
      (regs_ff.st == cprl_pkg::CPRL_ST_RECV && i_rec_valid && i_rec_last)
      |=> o_rec_done ##1 !o_rec_done;
  endproperty
  a_answer_next: assert property (p_answer_next) // [R3] [R4]
    else $error("completion not one cycle after last byte");

  property p_error_keeps_cfg;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_rec_done && o_rec_error) |->
      ($stable(o_mode) && $stable(regs_ff.basic) && $stable(regs_ff.enc)
       && $stable(o_cfg_valid));
  endproperty
  a_error_keeps_cfg: assert property (p_error_keeps_cfg) // [R2]
    else $error("configuration changed on rejected record");

  property p_good_length;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_rec_done && !o_rec_error) |->
      (o_rec_status == {8'h00, regs_ff.cnt} &&
       regs_ff.cnt >= cprl_pkg::REC_MIN_LEN);
  endproperty
  a_good_length: assert property (p_good_length) // [R4]
    else $error("good status is not the accepted byte count");

  property p_bad_index;
    @(posedge i_ref_clk) disable iff (i_rst)
      (regs_ff.st == cprl_pkg::CPRL_ST_IDLE && i_rec_start &&
       i_rec_index != cprl_pkg::REC_INDEX)
      |=> (regs_ff.code == cprl_pkg::ERR_INDEX);
  endproperty
  a_bad_index: assert property (p_bad_index) // [R1] [R14]
    else $error("wrong record number not flagged");

  // First error found must reach the completion status
  property p_code_to_status;
    @(posedge i_ref_clk) disable iff (i_rst)
      (regs_ff.st == cprl_pkg::CPRL_ST_RECV && i_rec_valid && i_rec_last
       && regs_ff.code != cprl_pkg::ERR_NONE)
      |=> (o_rec_error && o_rec_status == $past(regs_ff.code));
  endproperty
  a_code_to_status: assert property (p_code_to_status) // [R2] [R3]
    else $error("first error lost before completion");

  property p_run_mode_fixed;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_rec_done && !regs_ff.full && $past(o_cfg_valid))
      |-> $stable(o_mode);
  endproperty
  a_run_mode_fixed: assert property (p_run_mode_fixed) // [R6]
    else $error("function changed on a run-time write");

  property p_mode_legal;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cfg_valid |-> (o_mode == cprl_pkg::MODE_COUNT ||
                       o_mode == cprl_pkg::MODE_MEASURE);
  endproperty
  a_mode_legal: assert property (p_mode_legal) // [R7]
    else $error("reserved function applied");

  property p_iface_from_record;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_rec_done && !o_rec_error) |->
      (o_iface_ttl == regs_ff.stg_basic[cprl_pkg::BAS_IFACE_BIT] &&
       o_stop_react == regs_ff.stg_basic[1:0]);
  endproperty
  a_iface_from_record: assert property (p_iface_from_record) // [R8]
    else $error("interface standard not taken from record");

  property p_stop_legal;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cfg_valid |-> o_stop_react != cprl_pkg::STOP_RSV;
  endproperty
  a_stop_legal: assert property (p_stop_legal) // [R9]
    else $error("reserved stop reaction applied");

  property p_eval_legal;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cfg_valid |-> o_eval != cprl_pkg::EVAL_RSV;
  endproperty
  a_eval_legal: assert property (p_eval_legal) // [R10] [R11]
    else $error("reserved evaluation applied");

  property p_sig_legal;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cfg_valid |-> o_sig_type <= cprl_pkg::SIG_INCR_ABN;
  endproperty
  a_sig_legal: assert property (p_sig_legal) // [R12] [R13]
    else $error("reserved signal type applied");

  property p_header_reject;
    @(posedge i_ref_clk) disable iff (i_rst)
      (regs_ff.st == cprl_pkg::CPRL_ST_RECV && i_rec_valid && i_rec_last
       && regs_ff.cnt == cprl_pkg::OFS_VERSION
       && regs_ff.code == cprl_pkg::ERR_NONE
       && i_rec_data != cprl_pkg::HDR_VERSION)
      |=> (o_rec_error && o_rec_status == cprl_pkg::ERR_HEADER);
  endproperty
  a_header_reject: assert property (p_header_reject) // [R5] [R14]
    else $error("bad version byte not rejected");

  property p_busy_idle;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_rec_done |-> !o_rec_busy;
  endproperty
  a_busy_idle: assert property (p_busy_idle) // [R3] [R4]
    else $error("still busy at completion");

  property p_rsv_bits_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cfg_valid |->
      ((regs_ff.basic & cprl_pkg::BAS_RSV_MASK) == 8'h00 &&
       (regs_ff.enc & cprl_pkg::ENC_RSV_MASK) == 8'h00);
  endproperty
  a_rsv_bits_clear: assert property (p_rsv_bits_clear) // [R14]
    else $error("reserved bits set in applied configuration");

endmodule

// ---- verification/cprl_host.sv ----
// Host controller model issuing parameter record writes
`timescale 1ns/10ps
module cprl_host (
  // Clock and completion
  input  wire logic       i_ref_clk,
  input  wire logic       i_done,
  // Record write requests
  output logic            o_start,
  output logic [7:0]      o_index,
  output logic            o_full,
  output logic            o_valid,
  output logic [7:0]      o_data,
  output logic            o_last
);
  initial begin
    o_start = 1'b0;
    o_index = 8'h00;
    o_full  = 1'b0;
    o_valid = 1'b0;
    o_data  = 8'hA5;
    o_last  = 1'b0;
  end

  // ==========================================================
  // One write; bytes past offset 6 go out as zero
  task automatic send(input logic [7:0] idx, input logic full,
                      input logic [55:0] rec, input int n,
                      input int gap, output bit hung);
    int k;
    int w;
    o_start = 1'b1;
    o_index = idx;
    o_full  = full;
    @(negedge i_ref_clk);
    o_start = 1'b0;
    for (k = 0; k < n; k++) begin
      o_valid = 1'b1;
      o_data  = (k < 7) ? rec[55-8*k -: 8] : 8'h00;
      o_last  = (k == n - 1);
      @(negedge i_ref_clk);
      if (gap > 0 || k == n - 1) begin
        o_valid = 1'b0;
        o_last  = 1'b0;
        o_data  = ~o_data;
        repeat ((k < n - 1) ? gap : 0) @(negedge i_ref_clk);
      end
    end
    for (w = 0; w < 20 && i_done !== 1'b1; w++) @(negedge i_ref_clk);
    hung = (i_done !== 1'b1);
  endtask
endmodule

// ---- verification/cprl_loader_tb.sv ----
// Self-checking bench for the parameter record loader
`timescale 1ns/10ps
module cprl_loader_tb;
  typedef struct {
    logic [7:0]  idx;
    logic        full;
    logic [55:0] rec;
    int          n;
    int          gap;
    logic [15:0] code;
  } cprl_row_t;

  logic        clk;
  logic        rst;
  logic        start;
  logic [7:0]  index;
  logic        full;
  logic        valid;
  logic [7:0]  data;
  logic        last;
  logic        busy;
  logic        done;
  logic        error;
  logic [15:0] status;
  logic        cfg_valid;
  logic [3:0]  mode;
  logic        ttl;
  logic        diag;
  logic [1:0]  stop;
  logic [1:0]  eval;
  logic [3:0]  sig;
  logic [14:0] exp_cfg;
  int          n_mismatch;
  int          total_checks;

  cprl_row_t rows [20] = '{
    '{8'h80, 1'b1, 56'h01300000010513, 7, 0, cprl_pkg::ERR_NONE},
    '{8'h80, 1'b1, 56'h02300000010513, 7, 0, cprl_pkg::ERR_HEADER},
    '{8'h80, 1'b1, 56'h02300000010513, 1, 0, cprl_pkg::ERR_HEADER},
    '{8'h80, 1'b1, 56'h01310000010513, 7, 0, cprl_pkg::ERR_HEADER},
    '{8'h80, 1'b1, 56'h01300001010513, 7, 0, cprl_pkg::ERR_HEADER},
    '{8'h80, 1'b1, 56'h01300000030513, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h80, 1'b1, 56'h01300000000513, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h80, 1'b1, 56'h01300000110513, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h80, 1'b0, 56'h01300000020513, 7, 0, cprl_pkg::ERR_MODE_RUN},
    '{8'h80, 1'b1, 56'h01300000028024, 9, 2, cprl_pkg::ERR_NONE},
    '{8'h80, 1'b1, 56'h01300000020324, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h80, 1'b1, 56'h01300000020034, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h80, 1'b1, 56'h01300000020824, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h80, 1'b1, 56'h01300000020025, 7, 0, cprl_pkg::ERR_RESERVED},
    '{8'h81, 1'b1, 56'h01300000010513, 7, 0, cprl_pkg::ERR_INDEX},
    '{8'h80, 1'b1, 56'h01300000010513, 6, 0, cprl_pkg::ERR_LENGTH},
    '{8'h80, 1'b0, 56'h01300000020200, 7, 0, cprl_pkg::ERR_NONE},
    '{8'h80, 1'b1, 56'h01300000018402, 255, 0, cprl_pkg::ERR_NONE},
    '{8'h80, 1'b1, 56'h01300000010513, 256, 0, cprl_pkg::ERR_LENGTH},
    '{8'h80, 1'b1, 56'h01300000010513, 7, 1, cprl_pkg::ERR_NONE}
  };

  cprl_host cprl_host_i (
    .i_ref_clk (clk),
    .i_done    (done),
    .o_start   (start),
    .o_index   (index),
    .o_full    (full),
    .o_valid   (valid),
    .o_data    (data),
    .o_last    (last)
  );

  cprl_loader cprl_loader_i (
    .i_ref_clk    (clk),
    .i_rst        (rst),
    .i_rec_start  (start),
    .i_rec_index  (index),
    .i_rec_full   (full),
    .i_rec_valid  (valid),
    .i_rec_data   (data),
    .i_rec_last   (last),
    .o_rec_busy   (busy),
    .o_rec_done   (done),
    .o_rec_error  (error),
    .o_rec_status (status),
    .o_cfg_valid  (cfg_valid),
    .o_mode       (mode),
    .o_iface_ttl  (ttl),
    .o_diag_en    (diag),
    .o_stop_react (stop),
    .o_eval       (eval),
    .o_sig_type   (sig)
  );

  // ==========================================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // One record write with its expected outcome
  task automatic run(input cprl_row_t r);
    bit          hung;
    logic [15:0] exp_st;
    logic [14:0] seen_cfg;
    cprl_host_i.send(r.idx, r.full, r.rec, r.n, r.gap, hung);
    if (hung) begin
      n_mismatch++;
      stop_test();
    end
    exp_st = {8'h00, r.n[7:0]};
    if (r.code !== cprl_pkg::ERR_NONE)
      exp_st = r.code;
    else
      exp_cfg = {1'b1, r.rec[19:16], r.rec[15], r.rec[10], r.rec[9:8],
                 r.rec[5:4], r.rec[3:0]};
    seen_cfg = {cfg_valid, mode, ttl, diag, stop, eval, sig};
    check({15'h0000, error}, {15'h0000, exp_st !== {8'h00, r.n[7:0]}});
    check(status, exp_st);
    check({14'h0000, busy, done}, 16'h0001);
    check({1'b0, seen_cfg}, {1'b0, exp_cfg});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    exp_cfg = 15'h0000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    foreach (rows[i]) run(rows[i]);
    // Reset in mid-run clears everything
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check({busy, done, error, 13'h0000}, 16'h0000);
    check(status, 16'h0000);
    check({1'b0, cfg_valid, mode, ttl, diag, stop, eval, sig}, 16'h0000);
    exp_cfg = 15'h0000;
    rst = 1'b0;
    @(negedge clk);
    // Run-time write may set function before any accepted record
    run('{8'h80, 1'b0, 56'h01300000020200, 7, 0, cprl_pkg::ERR_NONE});
    run('{8'h80, 1'b0, 56'h01300000010200, 7, 0, cprl_pkg::ERR_MODE_RUN});
    stop_test();
  end
endmodule
